// ### logic/nvsram_host_pkg.sv
// Package: pin bundles, timing counts and command codes for the nvSRAM host
package nvsram_host_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_NS = 20;

  // Pin timing, in ns, and derived cycle counts (least times round up)
  localparam int T_SETUP_NS = 20;
  localparam int T_PULSE_NS = 45;
  localparam int T_HOLD_NS = 20;
  localparam int T_TURN_NS = 20;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TURN_CYC = (T_TURN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;

  // Software store and recall address sequence
  localparam logic [ADDR_W-1:0] SEQ_A0 = 15'h0e38;
  localparam logic [ADDR_W-1:0] SEQ_A1 = 15'h31c7;
  localparam logic [ADDR_W-1:0] SEQ_A2 = 15'h03e0;
  localparam logic [ADDR_W-1:0] SEQ_A3 = 15'h3c1f;
  localparam logic [ADDR_W-1:0] SEQ_A4 = 15'h303f;
  localparam logic [ADDR_W-1:0] SEQ_STORE = 15'h0fc0;
  localparam logic [ADDR_W-1:0] SEQ_RECALL = 15'h0c63;
  localparam int SEQ_LEN = 6;

  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_SW_STORE = 3'h2,
    CMD_SW_RECALL = 3'h3,
    CMD_HW_STORE = 3'h4
  } cmd_t;

  typedef struct packed {
    cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic chipSelect_n;
    logic outputEnable_n;
    logic writeEnable_n;
    logic [ADDR_W-1:0] byteAddress;
  } ctrl_pins_t;

endpackage

// ### logic/nvsram_seq_rom.sv
// Address lookup for the software store and recall read sequences
`timescale 1ns/1ps
module nvsram_seq_rom
(
  input wire logic [2:0] step,
  input wire logic recall,
  output logic [nvsram_host_pkg::ADDR_W-1:0] addr
);

  always_comb
  begin
    case (step)
      3'h0: addr = nvsram_host_pkg::SEQ_A0;
      3'h1: addr = nvsram_host_pkg::SEQ_A1;
      3'h2: addr = nvsram_host_pkg::SEQ_A2;
      3'h3: addr = nvsram_host_pkg::SEQ_A3;
      3'h4: addr = nvsram_host_pkg::SEQ_A4;
      3'h5: addr = recall ? nvsram_host_pkg::SEQ_RECALL
                          : nvsram_host_pkg::SEQ_STORE;
      default: addr = nvsram_host_pkg::SEQ_A0;
    endcase
  end

endmodule

// ### logic/nvsram_host_ctrl.sv
// Host-side access controller for a 32K x 8 nonvolatile SRAM
`timescale 1ns/1ps
// Functional notes
// - Host holds address through write end
// - Data valid before write ending edge
// - Host keeps OE high during writes
// - External low on busy starts store if anything was written since the last nonvolatile cycle
// - Six select reads start software store
// - Last read 0x0c63 starts recall
module nvsram_host_ctrl
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reqValid,
  input wire nvsram_host_pkg::req_t req,
  output logic reqReady,
  output logic rspValid,
  output logic [nvsram_host_pkg::DATA_W-1:0] rspData,
  output nvsram_host_pkg::ctrl_pins_t pins,
  input wire logic [nvsram_host_pkg::DATA_W-1:0] dataLinesIn,
  output logic [nvsram_host_pkg::DATA_W-1:0] dataLinesOut,
  output logic dataLinesOe,
  input wire logic storeBusyIn_n,
  output logic storeBusyOut_n,
  output logic storeBusyOe
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_PULSE = 3'b011,
    ST_HOLD = 3'b010,
    ST_TURN = 3'b110,
    ST_HWREQ = 3'b111
  } state_t;

  state_t state;
  nvsram_host_pkg::req_t cur;
  logic [nvsram_host_pkg::CNT_W-1:0] cnt;
  logic [2:0] seqStep;
  logic [nvsram_host_pkg::ADDR_W-1:0] seqAddr;

  function automatic logic isSeq(input nvsram_host_pkg::cmd_t c);
    isSeq = (c == nvsram_host_pkg::CMD_SW_STORE) ||
            (c == nvsram_host_pkg::CMD_SW_RECALL);
  endfunction

  function automatic logic isWrite(input nvsram_host_pkg::cmd_t c);
    isWrite = (c == nvsram_host_pkg::CMD_WRITE);
  endfunction

  nvsram_seq_rom nvsram_seq_rom_inst
  (
    .step(seqStep),
    .recall(cur.cmd == nvsram_host_pkg::CMD_SW_RECALL),
    .addr(seqAddr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state <= ST_IDLE;
      cur <= '0;
      cnt <= '0;
      seqStep <= 3'h0;
      reqReady <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          // Ready only while the pin is high: a running store refuses us
          reqReady <= storeBusyIn_n && !(reqValid && reqReady);
          if (reqValid && reqReady)
          begin
            cur <= req;
            seqStep <= 3'h0;
            cnt <= '0;
            if (req.cmd == nvsram_host_pkg::CMD_HW_STORE)
              state <= ST_HWREQ;
            else
              state <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          // Writes that find busy low during setup are abandoned
          if (!storeBusyIn_n && isWrite(cur.cmd))
          begin
            state <= ST_TURN;
            cnt <= '0;
          end
          else if (cnt == 4'(nvsram_host_pkg::SETUP_CYC - 1))
          begin
            state <= ST_PULSE;
            cnt <= '0;
          end
          else
            cnt <= cnt + 4'h1;
        end
        ST_PULSE:
        begin
          if (cnt == 4'(nvsram_host_pkg::PULSE_CYC - 1))
          begin
            state <= ST_HOLD;
            cnt <= '0;
          end
          else
            cnt <= cnt + 4'h1;
        end
        ST_HOLD:
        begin
          if (cnt == 4'(nvsram_host_pkg::HOLD_CYC - 1))
          begin
            cnt <= '0;
            // Sequence reads go back to back so nothing can intervene
            if (isSeq(cur.cmd) &&
                seqStep != 3'(nvsram_host_pkg::SEQ_LEN - 1))
            begin
              seqStep <= seqStep + 3'h1;
              state <= ST_SETUP;
            end
            else
              state <= ST_TURN;
          end
          else
            cnt <= cnt + 4'h1;
        end
        ST_TURN:
        begin
          if (cnt == 4'(nvsram_host_pkg::TURN_CYC - 1))
            state <= ST_IDLE;
          else
            cnt <= cnt + 4'h1;
        end
        ST_HWREQ:
        begin
          // Release after PULSE_CYC cycles; the device's own pull on the busy pin is not checked
          if (cnt == 4'(nvsram_host_pkg::PULSE_CYC - 1))
            state <= ST_TURN;
          else
            cnt <= cnt + 4'h1;
          if (cnt == 4'(nvsram_host_pkg::PULSE_CYC - 1))
            cnt <= '0;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, all registered from the current state view

  logic active;
  logic curWr;
  // Select rises in the hold of each sequence read: the device counts
  // only select-ended reads
  assign active = (state == ST_SETUP) || (state == ST_PULSE) ||
                  (state == ST_HOLD && !isSeq(cur.cmd));
  assign curWr = isWrite(cur.cmd);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pins <= '{1'b1, 1'b1, 1'b1, '0};
      dataLinesOut <= '0;
      dataLinesOe <= 1'b0;
    end
    else
    begin
      // Address stays put from setup through hold
      pins.byteAddress <= isSeq(cur.cmd) ? seqAddr : cur.addr;
      pins.chipSelect_n <= !active;
      // Output enable never low during a write
      pins.outputEnable_n <= !(active && !curWr &&
                               !isSeq(cur.cmd));
      pins.writeEnable_n <= !((state == ST_PULSE) && curWr);
      // Data driven from setup to hold, so it brackets the WE rise
      dataLinesOe <= active && curWr;
      dataLinesOut <= cur.wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      storeBusyOut_n <= 1'b0;
      storeBusyOe <= 1'b0;
    end
    else
    begin
      storeBusyOut_n <= 1'b0;
      storeBusyOe <= (state == ST_HWREQ);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read capture at the end of the strobe

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rspValid <= 1'b0;
      rspData <= '0;
    end
    else
    begin
      rspValid <= 1'b0;
      if (state == ST_HOLD && cnt == '0 && !curWr && !isSeq(cur.cmd))
      begin
        rspValid <= 1'b1;
        rspData <= dataLinesIn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_noOeDuringWrite;
    @(posedge clk_sys) disable iff (srst)
    !pins.writeEnable_n |-> pins.outputEnable_n;
  endproperty
  a_noOeDuringWrite: assert property (p_noOeDuringWrite)
    else $error("output enable low during write");

  property p_weNeedsCs;
    @(posedge clk_sys) disable iff (srst)
    !pins.writeEnable_n |-> !pins.chipSelect_n && dataLinesOe;
  endproperty
  a_weNeedsCs: assert property (p_weNeedsCs)
    else $error("write strobe without select or data");

  property p_addrStableWrite;
    @(posedge clk_sys) disable iff (srst)
    !pins.writeEnable_n |=> $stable(pins.byteAddress);
  endproperty
  a_addrStableWrite: assert property (p_addrStableWrite)
    else $error("address moved during write");

  property p_dataHoldAfterWe;
    @(posedge clk_sys) disable iff (srst)
    $rose(pins.writeEnable_n) |-> dataLinesOe && $stable(dataLinesOut);
  endproperty
  a_dataHoldAfterWe: assert property (p_dataHoldAfterWe)
    else $error("data not held at write end");

  property p_weWidth;
    @(posedge clk_sys) disable iff (srst)
    $fell(pins.writeEnable_n) |-> !pins.writeEnable_n [*2];
  endproperty
  a_weWidth: assert property (p_weWidth)
    else $error("write pulse too short");

  property p_noDriveIdle;
    @(posedge clk_sys) disable iff (srst)
    pins.chipSelect_n |-> !dataLinesOe;
  endproperty
  a_noDriveIdle: assert property (p_noDriveIdle)
    else $error("data driven while deselected");

  property p_noWriteWhenBusy;
    @(posedge clk_sys) disable iff (srst)
    !storeBusyIn_n && state == ST_SETUP && curWr |=> state == ST_TURN;
  endproperty
  a_noWriteWhenBusy: assert property (p_noWriteWhenBusy)
    else $error("write started while busy low");

  property p_readResp;
    @(posedge clk_sys) disable iff (srst)
    $fell(pins.outputEnable_n) |-> ##[1:6] rspValid;
  endproperty
  a_readResp: assert property (p_readResp)
    else $error("read gave no response");

endmodule

// ### test/nvsram_dev_model.sv
// Pin-level model of the 32K x 8 nonvolatile SRAM
`timescale 1ns/1ps
module nvsram_dev_model
#(
  parameter int BUSY_NS = 2000
)
(
  input wire nvsram_host_pkg::ctrl_pins_t pins,
  input wire logic [7:0] dataIn,
  input wire logic storeBusy_n,
  output logic [7:0] dataOut,
  output logic dataOe,
  output logic busyPull
);
  localparam logic [14:0] SEQ [5] = '{nvsram_host_pkg::SEQ_A0,
    nvsram_host_pkg::SEQ_A1, nvsram_host_pkg::SEQ_A2,
    nvsram_host_pkg::SEQ_A3, nvsram_host_pkg::SEQ_A4};
  logic [7:0] mem [0:32767];
  logic [7:0] nvCopy [0:32767];
  logic dirty = 1'b0;
  logic recalling = 1'b0;
  logic sawWrite = 1'b0;
  logic writing;
  int step = 0;
  initial busyPull = 1'b0;
  // Power-up recall of whatever the cells hold
  initial mem = nvCopy;
  assign dataOut = mem[pins.byteAddress];
  assign dataOe = !pins.chipSelect_n && !pins.outputEnable_n
    && pins.writeEnable_n
    && storeBusy_n && !recalling;
  assign writing = !pins.chipSelect_n && !pins.writeEnable_n
    && storeBusy_n && !recalling;
  ////////////////////////////////////////////////////////////////////
  // Byte lands at the ending edge, whichever control ends it
  always @(negedge writing)
    if (storeBusy_n)
    begin
      mem[pins.byteAddress] = dataIn;
      dirty = 1'b1;
    end
  task automatic nvStore();
    busyPull = 1'b1;
    nvCopy = mem;
    #(BUSY_NS);
    busyPull = 1'b0;
    dirty = 1'b0;
  endtask
  // Skipped when nothing was written since the last nonvolatile cycle
  always @(negedge storeBusy_n)
    if (!busyPull && dirty)
      nvStore();
  ////////////////////////////////////////////////////////////////////
  always @(negedge pins.writeEnable_n)
    sawWrite = 1'b1;
  always @(posedge pins.chipSelect_n)
  begin
    if (sawWrite)
      step = 0;
    else if (step == 5 && pins.byteAddress == nvsram_host_pkg::SEQ_STORE)
    begin
      step = 0;
      nvStore();
    end
    else if (step == 5 && pins.byteAddress == nvsram_host_pkg::SEQ_RECALL)
    begin
      step = 0;
      recalling = 1'b1;
      mem = nvCopy;
      #(BUSY_NS / 2);
      recalling = 1'b0;
      dirty = 1'b0;
    end
    else if (step < 5 && pins.byteAddress == SEQ[step])
      step++;
    else
      step = int'(pins.byteAddress == SEQ[0]);
    sawWrite = 1'b0;
  end
endmodule

// ### test/test_nvsram_async_access_port.sv
// Self-checking bench for the nvSRAM host access controller
`timescale 1ns/1ps
module test_nvsram_async_access_port;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic reqValid = 1'b0;
  nvsram_host_pkg::req_t req = '0;
  logic reqReady, rspValid, dataLinesOe, storeBusyOut_n, storeBusyOe;
  logic [7:0] rspData, dataLinesIn, dataLinesOut, devData;
  nvsram_host_pkg::ctrl_pins_t pins;
  logic devOe, devPull, storeBusyIn_n;
  logic extBusy_n = 1'b1;
  logic [7:0] shadow [0:32767];
  logic [7:0] expQ [$];
  logic [14:0] curAddr = '0;
  logic [7:0] curData = '0;
  logic [14:0] a;
  int miscompares = 0;
  int testsRun = 0;
  int cyc = 0;
  initial forever #10 clk_sys = ~clk_sys;
  // Floating lines show a moving pattern so a stale byte never matches
  assign dataLinesIn = dataLinesOe ? dataLinesOut : devOe ? devData : cyc[7:0];
  assign storeBusyIn_n = !(storeBusyOe && !storeBusyOut_n) && !devPull
    && extBusy_n;
  nvsram_host_ctrl nvsram_host_ctrl_inst (.clk_sys(clk_sys), .srst(srst),
    .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .pins(pins),
    .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
    .dataLinesOe(dataLinesOe), .storeBusyIn_n(storeBusyIn_n),
    .storeBusyOut_n(storeBusyOut_n), .storeBusyOe(storeBusyOe));
  // Busy times end off the clock edge, clear of sampling races
  nvsram_dev_model #(.BUSY_NS(2010)) nvsram_dev_model_inst (.pins(pins),
    .dataIn(dataLinesIn), .storeBusy_n(storeBusyIn_n), .dataOut(devData),
    .dataOe(devOe), .busyPull(devPull));
  ////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, exp);
    testsRun++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Valid is held until the edge that samples ready high
  task automatic issue(input nvsram_host_pkg::cmd_t c,
    input logic [14:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    reqValid <= 1'b1;
    req <= '{c, ad, d};
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (!reqReady && n < 400);
    check("request taken", reqReady, 1'b1);
    check("busy pin at take", storeBusyIn_n, 1'b1);
    reqValid <= 1'b0;
    // Noted at the take, when the previous access has already ended
    curAddr <= ad;
    curData <= d;
    if (c == nvsram_host_pkg::CMD_READ)
      expQ.push_back(shadow[ad]);
    if (c == nvsram_host_pkg::CMD_WRITE)
      shadow[ad] = d;
  endtask
  ////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      test_done();
    end
  end
  always @(posedge clk_sys)
    if (!srst)
    begin
      check("bus fight", dataLinesOe & devOe, 1'b0);
      if (rspValid && expQ.size() == 0)
        check("spare response", 1'b1, 1'b0);
      else if (rspValid)
        check("read byte", rspData, expQ.pop_front());
      if (!pins.writeEnable_n)
      begin
        check("oe in write", pins.outputEnable_n, 1'b1);
        check("select in write", pins.chipSelect_n, 1'b0);
        check("write address", pins.byteAddress, curAddr);
        check("write drive", dataLinesOe, 1'b1);
        check("write data", dataLinesOut, curData);
      end
    end
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h418d));
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    issue(nvsram_host_pkg::CMD_WRITE, 15'h0000, 8'ha5);
    issue(nvsram_host_pkg::CMD_WRITE, 15'h7fff, 8'h5a);
    for (int i = 0; i < 10; i++)
    begin
      a = 15'($urandom());
      issue(nvsram_host_pkg::CMD_WRITE, a, 8'($urandom()));
      issue(nvsram_host_pkg::CMD_READ, a, 8'h00);
    end
    issue(nvsram_host_pkg::CMD_READ, 15'h0000, 8'h00);
    issue(nvsram_host_pkg::CMD_READ, 15'h7fff, 8'h00);
    $display("test read write done");
    a = 15'($urandom());
    issue(nvsram_host_pkg::CMD_WRITE, a, 8'h11);
    issue(nvsram_host_pkg::CMD_SW_STORE, 15'h0000, 8'h00);
    issue(nvsram_host_pkg::CMD_WRITE, a, 8'h22);
    issue(nvsram_host_pkg::CMD_READ, a, 8'h00);
    issue(nvsram_host_pkg::CMD_SW_RECALL, 15'h0000, 8'h00);
    // Recall shows nothing on the busy pin, so the user waits it out
    repeat (100) @(posedge clk_sys);
    shadow[a] = 8'h11;
    issue(nvsram_host_pkg::CMD_READ, a, 8'h00);
    $display("test software store recall done");
    issue(nvsram_host_pkg::CMD_WRITE, a, 8'h33);
    issue(nvsram_host_pkg::CMD_HW_STORE, 15'h0000, 8'h00);
    issue(nvsram_host_pkg::CMD_WRITE, a, 8'h44);
    issue(nvsram_host_pkg::CMD_SW_RECALL, 15'h0000, 8'h00);
    repeat (100) @(posedge clk_sys);
    shadow[a] = 8'h33;
    issue(nvsram_host_pkg::CMD_READ, a, 8'h00);
    $display("test hardware store done");
    // Third party pulls the pin low as a write is taken: write dropped
    issue(nvsram_host_pkg::CMD_WRITE, a, 8'h66);
    extBusy_n <= 1'b0;
    shadow[a] = 8'h33;
    repeat (4) @(posedge clk_sys);
    extBusy_n <= 1'b1;
    @(posedge clk_sys);
    // Nothing written since the recall, so that store is skipped
    check("skipped store", storeBusyIn_n, 1'b1);
    issue(nvsram_host_pkg::CMD_READ, a, 8'h00);
    $display("test write refused while busy done");
    repeat (20) @(posedge clk_sys);
    check("responses left", 16'(expQ.size()), 16'h0000);
    test_done();
  end
endmodule
